// ---- core/hpc_pkg.sv ----
package hpc_pkg;
  // Register offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_MODE    = 8'h01;
  localparam logic [7:0] OFS_RT      = 8'h02;
  localparam logic [7:0] OFS_LIB     = 8'h03;
  localparam logic [7:0] OFS_SEQ0    = 8'h04;
  localparam logic [7:0] OFS_SEQ7    = 8'h0b;
  localparam logic [7:0] OFS_TRIG    = 8'h0c;
  localparam logic [7:0] OFS_DRVCFG  = 8'h1d;
  localparam logic [7:0] OFS_CTRL3   = 8'h1b;
  localparam int         NUM_SLOTS   = 8;
  // Fields
  localparam int BIT_RESET   = 7;
  localparam int BIT_STANDBY = 6;
  localparam int BIT_RESULT  = 3;
  localparam int BIT_FBTO    = 2;
  localparam int BIT_THERM   = 1;
  localparam int BIT_OCUR    = 0;
  localparam int BIT_FLOAT   = 4;
  localparam int BIT_WAIT    = 7;
  localparam int BIT_SIGNSEL = 3;
  localparam int BIT_ANASEL  = 1;
  localparam int BIT_ACCPL   = 5;
  // Reset values and write masks
  localparam logic [7:0] RST_MODE   = 8'h40;
  localparam logic [7:0] RST_SEQ0   = 8'h01;
  localparam logic [7:0] RST_DRVCFG = 8'h80;
  localparam logic [7:0] RST_CTRL3  = 8'h93;
  localparam logic [7:0] MASK_MODE  = 8'hc7;
  localparam logic [7:0] MASK_LIB   = 8'h17;
  localparam logic [7:0] MASK_CTRL3 = 8'hbf;
  // Timing
  localparam int CLK_HZ       = 200_000_000;
  localparam int WAIT_UNIT_MS = 10;
  localparam int WAIT_UNIT_CYC = CLK_HZ / 1000 * WAIT_UNIT_MS;
  localparam int RETRY_MS     = 10;
  localparam int RETRY_CYC    = CLK_HZ / 1000 * RETRY_MS;
  // Modes
  typedef enum logic [2:0] {
    MD_INTERNAL, MD_EDGE, MD_LEVEL, MD_PWM, MD_AUDIO, MD_REALTIME, MD_DIAG, MD_CAL
  } hpc_mode_t;
endpackage

// ---- core/hpc_regs.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Status bits 7:5 show part identifier
// - Status bit 3 holds last routine verdict
// - Verdict clears on read, valid after trigger
// - Feedback timeout flag sets, clears on read
// - Thermal flag latches, shuts down, read clears
// - Overcurrent latches, shutdown, periodic restart retry
// - Reset bit restores defaults, aborts, self-clears
// - Standby bit, default one, ready when zero
// - Mode 0 plays only on software trigger
// - Mode 1 edge sets trigger, second cancels
// - Mode 2 trigger follows pin level
// - Mode 3 drives from PWM or analog
// - Mode 4 audio to vibration
// - Mode 5 drives realtime register continuously
// - Realtime byte signed unless unsigned selected
// - Mode 6 diagnostic, self-clear, store verdict
// - Mode 7 calibration, self-clear, store results
// - Library select chooses waveform library
// - Wait entries idle ten ms per count
// - Play slots in order, stop at zero
// - Trigger stays high, host clear cancels
// - Bus target address 0x5A
module hpc_regs #(
  parameter int WAIT_CYC  = hpc_pkg::WAIT_UNIT_CYC,
  parameter int RETRY_CYC = hpc_pkg::RETRY_CYC,
  parameter logic [2:0] PART_ID = 3'h5 // Arbitrary identity value
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // Register port from the bus target logic (address 0x5A decoded there)
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // Pin and engine events
  input  wire logic       i_trig_pin,
  input  wire logic       i_temp_over,
  input  wire logic       i_low_impedance,
  input  wire logic       i_fb_timeout,
  input  wire logic       i_wave_done,
  input  wire logic       i_routine_done,
  input  wire logic       i_routine_fail,
  // Engine controls
  output logic            o_active,
  output logic [2:0]      o_mode,
  output logic            o_drive_enable,
  output logic [7:0]      o_drive_level,
  output logic            o_drive_signed,
  output logic            o_analog_input_select,
  output logic            o_audio_coupling_enable,
  output logic            o_output_float_bit,
  output logic [2:0]      o_library_select,
  output logic            o_wave_start,
  output logic [6:0]      o_wave_index,
  output logic            o_wave_abort,
  output logic            o_routine_start,
  output logic            o_routine_abort
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum {SQ_IDLE, SQ_LOAD, SQ_PLAY, SQ_WAIT, SQ_ROUTINE} hpc_seq_t;

  typedef struct packed {
    logic [1:0]  pin_sync;
    logic        pin_prev;
    logic [7:0]  mode;
    logic [7:0]  rt;
    logic [7:0]  lib;
    logic [7:0]  drvcfg;
    logic [7:0]  ctrl3;
    logic [hpc_pkg::NUM_SLOTS-1:0][7:0] seq;
    logic        trig;
    logic        result;
    logic        fbto;
    logic        therm;
    logic        ocur;
    logic        shut_oc;
    logic [31:0] retry_cnt;
    hpc_seq_t    sq;
    logic [2:0]  slot;
    logic [31:0] wait_cnt;
    logic [6:0]  wait_units;
    logic [7:0]  rdata;
    logic        active;
    logic        drive_en;
    logic        wstart;
    logic        wabort;
    logic        rstart;
    logic        rabort;
    logic [6:0]  windex;
  } hpc_state_t;

  hpc_state_t s_r;
  hpc_state_t s_nxt;

  logic        pin_rise;
  logic        pin_fall;
  logic        reg_write;
  logic        soft_reset;
  logic        host_clear;
  logic [7:0]  entry;
  logic [7:0]  status;
  logic        step;

  ////////////////////////////////////////////////////////////////////////////
  function automatic hpc_state_t reset_state();
    hpc_state_t d;
    d           = '0;
    d.mode      = hpc_pkg::RST_MODE;
    d.drvcfg    = hpc_pkg::RST_DRVCFG;
    d.ctrl3     = hpc_pkg::RST_CTRL3;
    d.seq[0]    = hpc_pkg::RST_SEQ0;
    d.sq        = SQ_IDLE;
    return d;
  endfunction

  always_comb begin
    s_nxt      = s_r;
    step       = 1'b0;
    pin_rise   = s_r.pin_sync[1] & ~s_r.pin_prev;
    pin_fall   = ~s_r.pin_sync[1] & s_r.pin_prev;
    reg_write  = i_wr;
    soft_reset = i_wr && i_addr == hpc_pkg::OFS_MODE && i_wdata[hpc_pkg::BIT_RESET];
    host_clear = i_wr && i_addr == hpc_pkg::OFS_TRIG && !i_wdata[0];
    entry      = s_r.seq[s_r.slot];
    status     = {PART_ID, 1'b0, s_r.result, s_r.fbto, s_r.therm, s_r.ocur};

    s_nxt.pin_sync = {s_r.pin_sync[0], i_trig_pin};
    s_nxt.pin_prev = s_r.pin_sync[1];
    s_nxt.wstart   = 1'b0;
    s_nxt.wabort   = 1'b0;
    s_nxt.rstart   = 1'b0;
    s_nxt.rabort   = 1'b0;

    // Register writes, undefined bits masked off
    if (reg_write) begin
      unique case (i_addr)
        hpc_pkg::OFS_MODE:   s_nxt.mode   = i_wdata & hpc_pkg::MASK_MODE & 8'h7f;
        hpc_pkg::OFS_RT:     s_nxt.rt     = i_wdata;
        hpc_pkg::OFS_LIB:    s_nxt.lib    = i_wdata & hpc_pkg::MASK_LIB;
        hpc_pkg::OFS_TRIG:   s_nxt.trig   = i_wdata[0];
        hpc_pkg::OFS_DRVCFG: s_nxt.drvcfg = i_wdata;
        hpc_pkg::OFS_CTRL3:  s_nxt.ctrl3  = i_wdata & hpc_pkg::MASK_CTRL3;
        default: begin
          if (i_addr >= hpc_pkg::OFS_SEQ0 && i_addr <= hpc_pkg::OFS_SEQ7) begin
            s_nxt.seq[i_addr[2:0] - 3'h4] = i_wdata;
          end
        end
      endcase
    end

    // External trigger modes
    if (s_r.mode[2:0] == hpc_pkg::MD_EDGE && pin_rise) begin
      s_nxt.trig = ~s_r.trig; // Second edge while busy cancels
    end
    if (s_r.mode[2:0] == hpc_pkg::MD_LEVEL && (pin_rise || pin_fall)) begin
      s_nxt.trig = s_r.pin_sync[1]; // No effect if already matching
    end

    // Faults: set wins over read-clear
    if (i_rd && i_addr == hpc_pkg::OFS_STATUS) begin
      s_nxt.result = 1'b0;
      s_nxt.fbto   = 1'b0;
      s_nxt.therm  = 1'b0;
      s_nxt.ocur   = 1'b0;
    end
    if (i_fb_timeout) s_nxt.fbto = 1'b1;
    if (i_temp_over)  s_nxt.therm = 1'b1;
    if (i_low_impedance && !s_r.shut_oc) begin
      s_nxt.ocur      = 1'b1;
      s_nxt.shut_oc   = 1'b1;
      s_nxt.retry_cnt = '0;
    end
    if (s_r.shut_oc) begin
      // Periodic restart attempt; impedance recheck each period
      s_nxt.retry_cnt = s_r.retry_cnt + 32'h1;
      if (s_r.retry_cnt >= 32'(RETRY_CYC - 1)) begin
        s_nxt.retry_cnt = '0;
        s_nxt.shut_oc   = i_low_impedance;
      end
    end

    // Sequencer and routines
    unique case (s_r.sq)
      SQ_IDLE: begin
        if (s_r.trig && !s_r.mode[hpc_pkg::BIT_STANDBY] && !s_r.therm && !s_r.shut_oc) begin
          if (s_r.mode[2:0] == hpc_pkg::MD_DIAG || s_r.mode[2:0] == hpc_pkg::MD_CAL) begin
            s_nxt.rstart = 1'b1;
            s_nxt.sq     = SQ_ROUTINE;
          end else if (s_r.mode[2:0] <= hpc_pkg::MD_LEVEL) begin
            s_nxt.slot = 3'h0;
            s_nxt.sq   = SQ_LOAD;
          end
        end
      end
      SQ_LOAD: begin
        if (entry == 8'h00) begin
          s_nxt.trig = 1'b0; // Zero id ends the sequence
          s_nxt.sq   = SQ_IDLE;
        end else if (entry[hpc_pkg::BIT_WAIT]) begin
          s_nxt.wait_units = entry[6:0];
          s_nxt.wait_cnt   = '0;
          s_nxt.sq         = SQ_WAIT;
        end else begin
          s_nxt.windex = entry[6:0];
          s_nxt.wstart = 1'b1;
          s_nxt.sq     = SQ_PLAY;
        end
      end
      SQ_PLAY, SQ_WAIT: begin
        if (s_r.sq == SQ_PLAY) begin
          step = i_wave_done;
        end else if (s_r.wait_units == 7'h0) begin
          step = 1'b1;
        end else if (s_r.wait_cnt >= 32'(WAIT_CYC - 1)) begin
          s_nxt.wait_cnt   = '0;
          s_nxt.wait_units = s_r.wait_units - 7'h1; // 10 ms per unit
        end else begin
          s_nxt.wait_cnt = s_r.wait_cnt + 32'h1;
        end
        if (step) begin
          if (s_r.slot == 3'(hpc_pkg::NUM_SLOTS - 1)) begin
            s_nxt.trig = 1'b0; // Last slot played
            s_nxt.sq   = SQ_IDLE;
          end else begin
            s_nxt.slot = s_r.slot + 3'h1;
            s_nxt.sq   = SQ_LOAD;
          end
        end
      end
      SQ_ROUTINE: begin
        if (i_routine_done) begin
          s_nxt.result = i_routine_fail; // Last routine's verdict
          s_nxt.trig   = 1'b0; // Self-clear marks result valid
          s_nxt.sq     = SQ_IDLE;
        end
      end
    endcase

    // Cancel when trigger is dropped or fault strikes mid-playback
    // Natural end already returns to idle, so it raises no abort
    if (s_r.sq != SQ_IDLE && s_nxt.sq != SQ_IDLE && (!s_nxt.trig || s_r.therm || s_r.shut_oc)) begin
      s_nxt.wabort = s_r.sq != SQ_ROUTINE;
      s_nxt.rabort = s_r.sq == SQ_ROUTINE;
      s_nxt.trig   = 1'b0;
      s_nxt.sq     = SQ_IDLE;
    end
    if (host_clear && s_r.sq != SQ_IDLE) s_nxt.wabort = s_r.sq != SQ_ROUTINE;

    // Continuous drive modes; host parks with mode 0 or standby
    s_nxt.drive_en = !s_nxt.mode[hpc_pkg::BIT_STANDBY] && !s_nxt.therm && !s_nxt.shut_oc &&
                     (s_nxt.mode[2:0] == hpc_pkg::MD_PWM || s_nxt.mode[2:0] == hpc_pkg::MD_AUDIO ||
                      s_nxt.mode[2:0] == hpc_pkg::MD_REALTIME);
    s_nxt.active = s_nxt.sq != SQ_IDLE || s_nxt.drive_en;

    // Read data
    s_nxt.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        hpc_pkg::OFS_STATUS: s_nxt.rdata = status;
        hpc_pkg::OFS_MODE:   s_nxt.rdata = s_r.mode;
        hpc_pkg::OFS_RT:     s_nxt.rdata = s_r.rt;
        hpc_pkg::OFS_LIB:    s_nxt.rdata = s_r.lib;
        hpc_pkg::OFS_TRIG:   s_nxt.rdata = {7'h0, s_r.trig};
        hpc_pkg::OFS_DRVCFG: s_nxt.rdata = s_r.drvcfg;
        hpc_pkg::OFS_CTRL3:  s_nxt.rdata = s_r.ctrl3;
        default: begin
          if (i_addr >= hpc_pkg::OFS_SEQ0 && i_addr <= hpc_pkg::OFS_SEQ7) begin
            s_nxt.rdata = s_r.seq[i_addr[2:0] - 3'h4];
          end
        end
      endcase
    end

    // Software reset acts like a power cycle; abort pulses survive it
    if (soft_reset) begin
      s_nxt          = reset_state();
      s_nxt.pin_sync = {s_r.pin_sync[0], i_trig_pin};
      s_nxt.pin_prev = s_r.pin_sync[1];
      s_nxt.wabort   = 1'b1;
      s_nxt.rabort   = s_r.sq == SQ_ROUTINE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r <= reset_state();
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_rdata                 = s_r.rdata;
  assign o_active                = s_r.active;
  assign o_mode                  = s_r.mode[2:0];
  assign o_drive_enable          = s_r.drive_en;
  assign o_drive_level           = s_r.rt;
  assign o_drive_signed          = ~s_r.drvcfg[hpc_pkg::BIT_SIGNSEL];
  assign o_analog_input_select   = s_r.drvcfg[hpc_pkg::BIT_ANASEL];
  assign o_audio_coupling_enable = s_r.ctrl3[hpc_pkg::BIT_ACCPL];
  assign o_output_float_bit      = s_r.lib[hpc_pkg::BIT_FLOAT];
  assign o_library_select        = s_r.lib[2:0];
  assign o_wave_start            = s_r.wstart;
  assign o_wave_index            = s_r.windex;
  assign o_wave_abort            = s_r.wabort;
  assign o_routine_start         = s_r.rstart;
  assign o_routine_abort         = s_r.rabort;

endmodule

// ---- tb/hpc_engine_model.sv ----
`timescale 1ns/1ps
module hpc_engine_model #(
  parameter int DLY = 30
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_wave_start,
  input  wire logic i_wave_abort,
  input  wire logic i_routine_start,
  input  wire logic i_routine_abort,
  input  wire logic i_fail,
  output logic      o_wave_done,
  output logic      o_routine_done,
  output logic      o_routine_fail
);
  int wcnt;
  int rcnt;
  always_ff @(posedge i_clk) begin
    o_wave_done <= 1'b0;
    o_routine_done <= 1'b0;
    // Verdict line carries junk outside the done pulse
    o_routine_fail <= (rcnt == 1) ? i_fail : !i_fail;
    if (i_srst || i_wave_abort) wcnt <= 0;
    else if (i_wave_start) wcnt <= DLY;
    else if (wcnt > 0) begin
      wcnt <= wcnt - 1;
      o_wave_done <= (wcnt == 1);
    end
    if (i_srst || i_routine_abort) rcnt <= 0;
    else if (i_routine_start) rcnt <= DLY;
    else if (rcnt > 0) begin
      rcnt <= rcnt - 1;
      o_routine_done <= (rcnt == 1);
    end
  end
endmodule

// ---- tb/hpc_regs_chk.sv ----
`timescale 1ns/1ps
module hpc_regs_chk #(
  parameter logic [2:0] PART_ID = 3'h5
) (
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_active,
  input wire logic [2:0] o_mode,
  input wire logic [7:0] o_drive_level,
  input wire logic       o_drive_signed,
  input wire logic [2:0] o_library_select,
  input wire logic       o_wave_start,
  input wire logic [6:0] o_wave_index,
  input wire logic       o_wave_abort
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  AST_STATUS_ID: assert property (i_rd && i_addr == 8'h00 |=> o_rdata[7:4] == {PART_ID, 1'b0})
    else $error("status identity field wrong");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  AST_GAP_ZERO: assert property (i_rd && i_addr inside {[8'h0d:8'h1a]} |=> o_rdata == 8'h00)
    else $error("unmapped offset not zero");
  AST_RESET_BIT: assert property (i_rd && i_addr == 8'h01 |=> o_rdata[7:3] == {1'b0, o_rdata[6], 3'h0})
    else $error("mode reset bit or gap bits set");
  AST_RT_LEVEL: assert property (i_wr && i_addr == 8'h02 |=> o_drive_level == $past(i_wdata))
    else $error("realtime level not applied");
  AST_SIGN_SEL: assert property (i_wr && i_addr == 8'h1d |=> o_drive_signed == !$past(i_wdata[3]))
    else $error("sign select not applied");
  AST_LIBRARY: assert property (i_wr && i_addr == 8'h03 |=> o_library_select == $past(i_wdata[2:0]))
    else $error("library select not applied");
  AST_WAVE_NONZERO: assert property (o_wave_start |-> o_wave_index != 7'h00)
    else $error("zero identifier played");
  AST_CANCEL: assert property (i_wr && i_addr == 8'h0c && !i_wdata[0] && o_active && o_mode == 3'h0
    |-> ##[1:2] o_wave_abort)
    else $error("host cancel did not abort");
  AST_DEV_RESET: assert property (i_wr && i_addr == 8'h01 && i_wdata[7] |-> ##[1:3] (o_mode == 3'h0
    && o_drive_signed && !o_active))
    else $error("device reset did not restore defaults");
endmodule
bind hpc_regs hpc_regs_chk #(.PART_ID(PART_ID)) u_hpc_regs_chk (.i_clk, .i_srst, .i_wr, .i_rd, .i_addr,
  .i_wdata, .o_rdata, .o_active, .o_mode, .o_drive_level, .o_drive_signed, .o_library_select,
  .o_wave_start, .o_wave_index, .o_wave_abort);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam logic [2:0] PID = 3'h2; // Arbitrary identity value
  logic i_clk, i_srst, i_wr, i_rd, i_trig_pin, i_temp_over, i_low_impedance, i_fb_timeout, fail_sel;
  logic i_wave_done, i_routine_done, i_routine_fail, o_active, o_drive_enable, o_drive_signed;
  logic o_wave_start, o_wave_abort, o_routine_start, o_routine_abort, o_audio_coupling_enable;
  logic o_analog_input_select, o_output_float_bit;
  logic [7:0] i_addr, i_wdata, o_rdata, o_drive_level, d;
  logic [2:0] o_mode, o_library_select;
  logic [6:0] o_wave_index;
  logic [6:0] idx_q[$];
  int t_q[$];
  int fails, n_tests, n_abort, n_rabort, cnum;
  hpc_regs #(.WAIT_CYC(20), .RETRY_CYC(20), .PART_ID(PID)) u_hpc_regs (.i_clk, .i_srst, .i_wr, .i_rd,
    .i_addr, .i_wdata, .o_rdata, .i_trig_pin, .i_temp_over, .i_low_impedance, .i_fb_timeout, .i_wave_done,
    .i_routine_done, .i_routine_fail, .o_active, .o_mode, .o_drive_enable, .o_drive_level, .o_drive_signed,
    .o_analog_input_select, .o_audio_coupling_enable, .o_output_float_bit, .o_library_select,
    .o_wave_start, .o_wave_index, .o_wave_abort, .o_routine_start, .o_routine_abort);
  hpc_engine_model u_hpc_engine_model (.i_clk, .i_srst, .i_wave_start(o_wave_start),
    .i_wave_abort(o_wave_abort), .i_routine_start(o_routine_start), .i_routine_abort(o_routine_abort),
    .i_fail(fail_sel), .o_wave_done(i_wave_done), .o_routine_done(i_routine_done),
    .o_routine_fail(i_routine_fail));
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cnum++;
    if (!i_srst && o_wave_start) begin
      idx_q.push_back(o_wave_index);
      t_q.push_back(cnum);
    end
    if (!i_srst && o_wave_abort) n_abort++;
    if (!i_srst && o_routine_abort) n_rabort++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk);
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = v;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_rd = 1'b1;
    i_addr = a;
    @(negedge i_clk);
    i_rd = 1'b0;
    d = o_rdata;
    chk(d, e);
  endtask
  // Poll the active output; bounded so a stuck routine cannot hang the run
  task automatic wait_idle;
    int k;
    k = 0;
    @(negedge i_clk);
    while (k < 400 && u_hpc_regs.o_active !== 1'b0) begin
      cyc(1);
      k++;
    end
    cyc(4);
    rd(8'h0c, 8'h00);
  endtask
  task conclude;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    {i_clk, i_wr, i_rd, i_trig_pin, i_temp_over, i_low_impedance, i_fb_timeout, fail_sel} = '0;
    {i_addr, i_wdata} = '0;
    i_srst = 1'b1;
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 1'b0;
    rd(8'h00, {PID, 5'h00});
    rd(8'h01, 8'h40);
    rd(8'h04, 8'h01);
    rd(8'h20, 8'h00);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h17);
    chk({4'h0, o_output_float_bit, o_library_select}, 8'h0f);
    wr(8'h01, 8'h7f);
    rd(8'h01, 8'h47);
    $display("test defaults done");
    wr(8'h01, 8'h00);
    wr(8'h04, 8'h05);
    wr(8'h05, 8'h82);
    wr(8'h06, 8'h07);
    wr(8'h07, 8'h00);
    wr(8'h08, 8'h09);
    wr(8'h0c, 8'h01);
    wait_idle();
    chk(8'(idx_q.size()), 8'h02);
    chk(8'(n_abort), 8'h00);
    chk({1'b0, idx_q[0]}, 8'h05);
    chk({1'b0, idx_q[1]}, 8'h07);
    chk({7'h0, (t_q[1] - t_q[0]) inside {[70:100]}}, 8'h01);
    n_abort = 0;
    wr(8'h0c, 8'h01);
    cyc(5);
    wr(8'h0c, 8'h00);
    cyc(3);
    chk(8'(n_abort), 8'h01);
    $display("test sequence done");
    wr(8'h01, 8'h01);
    n_abort = 0;
    i_trig_pin = 1'b1;
    cyc(8);
    rd(8'h0c, 8'h01);
    i_trig_pin = 1'b0;
    cyc(4);
    i_trig_pin = 1'b1;
    cyc(8);
    rd(8'h0c, 8'h00);
    chk(8'(n_abort), 8'h01);
    i_trig_pin = 1'b0;
    wr(8'h01, 8'h02);
    i_trig_pin = 1'b1;
    cyc(8);
    rd(8'h0c, 8'h01);
    i_trig_pin = 1'b0;
    cyc(8);
    rd(8'h0c, 8'h00);
    $display("test pin modes done");
    n_rabort = 0;
    for (int m = 6; m <= 7; m++) begin
      fail_sel = (m == 6);
      wr(8'h01, 8'(m));
      wr(8'h0c, 8'h01);
      wait_idle();
      rd(8'h00, {PID, 1'b0, fail_sel, 3'h0});
      rd(8'h00, {PID, 5'h00});
    end
    chk(8'(n_rabort), 8'h00);
    $display("test routines done");
    wr(8'h01, 8'h03);
    cyc(2);
    chk({7'h0, o_drive_enable}, 8'h01);
    wr(8'h01, 8'h04);
    wr(8'h1b, 8'hff);
    rd(8'h1b, 8'hbf);
    chk({6'h0, o_audio_coupling_enable, o_drive_enable}, 8'h03);
    wr(8'h01, 8'h05);
    wr(8'h02, 8'h9c);
    cyc(2);
    chk({7'h0, o_drive_enable}, 8'h01);
    chk(o_drive_level, 8'h9c);
    {i_temp_over, i_fb_timeout, i_low_impedance} = 3'h7;
    cyc(1);
    {i_temp_over, i_fb_timeout, i_low_impedance} = 3'h0;
    cyc(3);
    chk({7'h0, o_drive_enable}, 8'h00);
    rd(8'h00, {PID, 5'h07});
    rd(8'h00, {PID, 5'h00});
    cyc(30);
    chk({7'h0, o_drive_enable}, 8'h01);
    wr(8'h1d, 8'h0a);
    cyc(1);
    chk({7'h0, o_drive_signed}, 8'h00);
    chk({7'h0, o_analog_input_select}, 8'h01);
    wr(8'h01, 8'h45);
    cyc(2);
    chk({7'h0, o_drive_enable}, 8'h00);
    wr(8'h01, 8'h80);
    cyc(3);
    rd(8'h01, 8'h40);
    rd(8'h04, 8'h01);
    rd(8'h02, 8'h00);
    chk({7'h0, o_drive_signed}, 8'h01);
    chk({7'h0, o_analog_input_select}, 8'h00);
    $display("test drive and reset done");
    conclude();
  end
endmodule
